// >>> hdl/npic_defines.svh
// register offsets, field layout, reset values and encodings of the interrupt controller
// Notes on behaviour
// - serve highest software priority; ties go to highest fixed hardware priority
// - a request not served at once stays latched until it wins
// - hardware priorities are unique, so exactly one request wins
// - top-level interrupt, reset and trap rank above every programmable level
// - reset and trap ignore the level bits, enter at level 3; reset wakes from halt, trap runs only from run
// - trap is taken on the trap instruction; its routine stays preemptible by top-level
// - reset has highest priority; first routine runs at level 3
// - maskable request served only if enabled and its level beats the current one
// - top-level interrupt raised on the selected pin edge, served like the trap
// - external edge requests are latched, cleared on entry, and wake from halt
// - selected pins of one external group are ORed together
// - peripheral request is its status flag ANDed with its enable bit
// - the peripheral clear sequence resets the latch, dropping a pending request
// - every source wakes from wait; only halt-capable sources wake from halt
// - leaving halt, a halt-capable request is served first, the others after
// - nesting by level; fixed order main, sources 13..1, then top-level
// - level pairs: 0=10, 1=01, 2=00, 3=11; level 3 masks maskable only
// - on entry the level bits load from the vector's programmed pair
// - writing pattern 10 into a pair is ignored; other pairs update
// - priority registers reset to all ones; upper nibble of the fourth reads ones
// - the top-level pair is stored but unused; top-level, trap, reset load 11
// - raising a running vector's pair while it pends re-enters it
// - enable, halt and wait load 10; disable and trap 11; return and pop restore
// - service starts at the instruction boundary, level from the vector's pair
// - edge select: 0 falling, 1 rising; writable only while top-level disabled
`ifndef NPIC_DEFINES_SVH
`define NPIC_DEFINES_SVH

`define NPIC_OFF_CC      8'h00
`define NPIC_OFF_PRIO0   8'h04
`define NPIC_OFF_PRIO1   8'h08
`define NPIC_OFF_PRIO2   8'h0C
`define NPIC_OFF_PRIO3   8'h10
`define NPIC_OFF_CTRL    8'h14
`define NPIC_OFF_EXTSEL  8'h18
`define NPIC_OFF_STATUS  8'h1C

`define NPIC_PRIO_RST    8'hFF
`define NPIC_PRIO3_RO    8'hF0
`define NPIC_LVL0_PAT    2'h2
`define NPIC_LVL3_PAT    2'h3
`define NPIC_CC_TOP      2'h3
`define NPIC_CC_HI_BIT   5
`define NPIC_CC_LO_BIT   3
`define NPIC_CTRL_TEN    0
`define NPIC_CTRL_TSEL   1

`define NPIC_NUM_VEC     14
`define NPIC_VEC_TOP     4'h0
`define NPIC_VEC_TRAP    4'hE
`define NPIC_VEC_NONE    4'hF
`define NPIC_EXT_FIRST   2
`define NPIC_HALT_CAP    14'h20BF
`define NPIC_HSIZE_WORD  3'h2

`endif

// >>> hdl/npic_pkg.sv
// shared types of the nested priority interrupt controller
package npic_pkg;
    typedef enum logic [1:0] {st_run, st_wait, st_halt} npic_state_t;
    typedef enum logic [2:0] {
        i_none, i_enable, i_disable, i_halt, i_wait, i_trap, i_return, i_pop
    } npic_instr_t;

    // level bit pair to a plain ordinal, 0 (main) .. 3 (disabled)
    function automatic logic [1:0] npic_lvl(input logic [1:0] pair);
        case (pair)
            2'h2:    npic_lvl = 2'h0;
            2'h1:    npic_lvl = 2'h1;
            2'h0:    npic_lvl = 2'h2;
            default: npic_lvl = 2'h3;
        endcase
    endfunction
endpackage

// >>> hdl/npic_req_latch.sv
// one request latch with optional edge detection and an arm gate
`timescale 1ns/1ps
module npic_req_latch #(
    parameter bit EDGE = 1'b1
) (
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // source side
    input  wire logic src,
    input  wire logic inv,
    input  wire logic arm,
    // service side
    input  wire logic clr_req,
    output logic      pend
);
    logic lvl;
    logic prev;
    logic set_req;

    assign lvl     = src ^ inv;
    assign set_req = arm & (EDGE ? (lvl & ~prev) : lvl);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev <= 1'b0;
        end else begin
            prev <= lvl;
        end
    end

    // a new event in the clearing cycle is kept
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend <= 1'b0;
        end else begin
            pend <= set_req | (pend & ~clr_req);
        end
    end
endmodule

// >>> hdl/npic_top.sv
// nested priority interrupt controller with an ahb-lite register slave
//
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`include "npic_defines.svh"
module npic_top
    import npic_pkg::*;
#(
    parameter int NUM_EXT  = 4,
    parameter int EXT_PINS = 4
) (
    // ahb-lite slave
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    input  wire logic                          hsel,
    input  wire logic [31:0]                   haddr,
    input  wire logic [1:0]                    htrans,
    input  wire logic                          hwrite,
    input  wire logic [2:0]                    hsize,
    input  wire logic                          hready,
    input  wire logic [31:0]                   hwdata,
    output logic                               hreadyout,
    output logic                               hresp,
    output logic [31:0]                        hrdata,
    // cpu core
    input  wire logic                          instr_boundary,
    input  wire npic_instr_t                   instr_code,
    input  wire logic [1:0]                    stack_prio,
    output logic                               irq_take,
    output logic [3:0]                         irq_vec,
    output logic                               prio_bit_high,
    output logic                               prio_bit_low,
    output logic                               jump_if_masked,
    output logic                               cpu_run,
    // interrupt sources
    input  wire logic                          top_irq_pin,
    input  wire logic [NUM_EXT*EXT_PINS-1:0]   ext_irq_pins,
    input  wire logic [`NPIC_NUM_VEC-1:0]      periph_flag,
    input  wire logic [`NPIC_NUM_VEC-1:0]      periph_en,
    input  wire logic [`NPIC_NUM_VEC-1:0]      periph_clear
);
    localparam int                    NV       = `NPIC_NUM_VEC;
    localparam int                    EXT_W    = NUM_EXT * EXT_PINS;
    localparam logic [NV-1:0]         HALT_CAP = `NPIC_HALT_CAP;

    // pin synchronisers
    logic [1:0]       top_sync;
    logic [EXT_W-1:0] ext_meta;
    logic [EXT_W-1:0] ext_sync;

    // register state
    logic [7:0]       ispr [4];
    logic [31:0]      prio_pairs;
    logic [1:0]       cc;
    logic             top_en;
    logic             top_sel;
    logic [EXT_W-1:0] ext_sel;
    npic_state_t      state;
    npic_state_t      next_state;
    logic [NV-1:0]    pend;

    // bus pipeline
    logic             accept;
    logic             wr_pend;
    logic             rd_pend;
    logic [7:0]       addr_q;
    logic [31:0]      rd_mux;

    // arbitration
    logic             boundary_run;
    logic             trap_now;
    logic             take_now;
    logic [1:0]       next_cc;
    logic [1:0]       cur_lvl;
    logic [1:0]       entry_pair;
    logic [NV-1:0]    cand;
    logic [NV-1:0]    take_onehot;
    logic             sel_ok;
    logic [3:0]       sel_vec;
    logic [1:0]       sel_lvl;
    logic [1:0]       lvl_before_q;

    assign cc         = {prio_bit_high, prio_bit_low};
    assign prio_pairs = {ispr[3], ispr[2], ispr[1], ispr[0]};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            top_sync <= 2'h0;
            ext_meta <= '0;
            ext_sync <= '0;
        end else begin
            top_sync <= {top_sync[0], top_irq_pin};
            ext_meta <= ext_irq_pins;
            ext_sync <= ext_meta;
        end
    end

    // ---------------- ahb-lite slave ----------------
    // writes complete with no wait state; reads add one so hrdata comes from a flop
    assign accept = hsel && hready && htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend   <= 1'b0;
            rd_pend   <= 1'b0;
            addr_q    <= 8'h00;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
        end else begin
            wr_pend   <= accept && hwrite && (hsize == `NPIC_HSIZE_WORD);
            rd_pend   <= accept && !hwrite;
            hreadyout <= !(accept && !hwrite);
            hresp     <= 1'b0;
            if (accept) begin
                addr_q <= haddr[7:0];
            end
            if (rd_pend) begin
                hrdata <= rd_mux;
            end
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (addr_q == `NPIC_OFF_CC) begin
            rd_mux[7:6]              = 2'h3;
            rd_mux[`NPIC_CC_HI_BIT]  = cc[1];
            rd_mux[`NPIC_CC_LO_BIT]  = cc[0];
        end else if (addr_q == `NPIC_OFF_PRIO0) begin
            rd_mux[7:0] = ispr[0];
        end else if (addr_q == `NPIC_OFF_PRIO1) begin
            rd_mux[7:0] = ispr[1];
        end else if (addr_q == `NPIC_OFF_PRIO2) begin
            rd_mux[7:0] = ispr[2];
        end else if (addr_q == `NPIC_OFF_PRIO3) begin
            rd_mux[7:0] = ispr[3];
        end else if (addr_q == `NPIC_OFF_CTRL) begin
            rd_mux[`NPIC_CTRL_TEN]  = top_en;
            rd_mux[`NPIC_CTRL_TSEL] = top_sel;
        end else if (addr_q == `NPIC_OFF_EXTSEL) begin
            rd_mux[EXT_W-1:0] = ext_sel;
        end else if (addr_q == `NPIC_OFF_STATUS) begin
            rd_mux[NV-1:0]  = pend;
            rd_mux[17:16]   = state;
            rd_mux[23:20]   = irq_vec;
        end
    end

    // keep the old pair wherever the level-0 pattern is written
    function automatic logic [7:0] prio_merge(input logic [7:0] old, input logic [7:0] din);
        for (int p = 0; p < 4; p++) begin
            prio_merge[2*p +: 2] = (din[2*p +: 2] == `NPIC_LVL0_PAT) ? old[2*p +: 2]
                                                                      : din[2*p +: 2];
        end
    endfunction

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 4; i++) begin
                ispr[i] <= `NPIC_PRIO_RST;
            end
        end else if (wr_pend) begin
            if (addr_q == `NPIC_OFF_PRIO0) begin
                ispr[0] <= prio_merge(ispr[0], hwdata[7:0]);
            end else if (addr_q == `NPIC_OFF_PRIO1) begin
                ispr[1] <= prio_merge(ispr[1], hwdata[7:0]);
            end else if (addr_q == `NPIC_OFF_PRIO2) begin
                ispr[2] <= prio_merge(ispr[2], hwdata[7:0]);
            end else if (addr_q == `NPIC_OFF_PRIO3) begin
                ispr[3] <= prio_merge(ispr[3], hwdata[7:0]) | `NPIC_PRIO3_RO;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            top_en  <= 1'b0;
            top_sel <= 1'b0;
            ext_sel <= '0;
        end else if (wr_pend) begin
            if (addr_q == `NPIC_OFF_CTRL) begin
                top_en <= hwdata[`NPIC_CTRL_TEN];
                // changing the edge while armed could fake an edge
                if (!top_en) begin
                    top_sel <= hwdata[`NPIC_CTRL_TSEL];
                end
            end else if (addr_q == `NPIC_OFF_EXTSEL) begin
                ext_sel <= hwdata[EXT_W-1:0];
            end
        end
    end

    // ---------------- request latches ----------------
    for (genvar v = 0; v < NV; v++) begin : g_src
        if (v == 0) begin : g_top
            npic_req_latch #(.EDGE(1'b1)) u_latch (
                .hclk    (hclk),
                .hresetn (hresetn),
                .src     (top_sync[1]),
                .inv     (~top_sel),
                .arm     (top_en),
                .clr_req (take_onehot[v]),
                .pend    (pend[v])
            );
        end else if (v >= `NPIC_EXT_FIRST && v < `NPIC_EXT_FIRST + NUM_EXT) begin : g_ext
            localparam int G = v - `NPIC_EXT_FIRST;
            npic_req_latch #(.EDGE(1'b1)) u_latch (
                .hclk    (hclk),
                .hresetn (hresetn),
                .src     (|(ext_sync[G*EXT_PINS +: EXT_PINS] &
                            ext_sel[G*EXT_PINS +: EXT_PINS])),
                .inv     (1'b0),
                .arm     (1'b1),
                .clr_req (take_onehot[v]),
                .pend    (pend[v])
            );
        end else begin : g_per
            npic_req_latch #(.EDGE(1'b0)) u_latch (
                .hclk    (hclk),
                .hresetn (hresetn),
                .src     (periph_flag[v]),
                .inv     (1'b0),
                .arm     (periph_en[v]),
                .clr_req (periph_clear[v]),
                .pend    (pend[v])
            );
        end
    end

    // ---------------- level bits and arbitration ----------------
    assign boundary_run = instr_boundary && (state == st_run);
    assign trap_now     = boundary_run && (instr_code == i_trap);

    always_comb begin
        next_cc = cc;
        if (wr_pend && addr_q == `NPIC_OFF_CC) begin
            next_cc = {hwdata[`NPIC_CC_HI_BIT], hwdata[`NPIC_CC_LO_BIT]};
        end
        if (boundary_run) begin
            case (instr_code)
                i_enable, i_halt, i_wait: next_cc = `NPIC_LVL0_PAT;
                i_disable, i_trap:        next_cc = `NPIC_LVL3_PAT;
                i_return, i_pop:          next_cc = stack_prio;
                default:                  next_cc = next_cc;
            endcase
        end
    end

    assign cur_lvl = npic_lvl(next_cc);

    // a raised pair of a running vector that still pends re-enters it
    always_comb begin
        cand = '0;
        for (int v = 1; v < NV; v++) begin
            cand[v] = pend[v] && (npic_lvl(prio_pairs[2*v +: 2]) > cur_lvl);
        end
        cand[0] = pend[0] && top_en;
        if (state == st_halt) begin
            cand = cand & HALT_CAP;
        end
    end

    // scan from the lowest fixed priority so the lower index wins a tie
    always_comb begin
        sel_ok  = 1'b0;
        sel_vec = `NPIC_VEC_NONE;
        sel_lvl = 2'h0;
        for (int v = NV - 1; v >= 1; v--) begin
            if (cand[v] && (!sel_ok || npic_lvl(prio_pairs[2*v +: 2]) >= sel_lvl)) begin
                sel_ok  = 1'b1;
                sel_vec = 4'(v);
                sel_lvl = npic_lvl(prio_pairs[2*v +: 2]);
            end
        end
        if (cand[0]) begin
            sel_ok  = 1'b1;
            sel_vec = `NPIC_VEC_TOP;
        end
        if (trap_now) begin
            sel_ok  = 1'b1;
            sel_vec = `NPIC_VEC_TRAP;
        end
    end

    // a sleeping core is woken by taking the winner directly
    assign take_now    = sel_ok && (boundary_run || state != st_run);
    assign take_onehot = take_now ? (NV'(1) << sel_vec) : '0;

    always_comb begin
        if (sel_vec == `NPIC_VEC_TOP || sel_vec == `NPIC_VEC_TRAP) begin
            entry_pair = `NPIC_CC_TOP;
        end else begin
            entry_pair = prio_pairs[{sel_vec, 1'b0} +: 2];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {prio_bit_high, prio_bit_low} <= `NPIC_LVL3_PAT;
            jump_if_masked                <= 1'b1;
        end else begin
            {prio_bit_high, prio_bit_low} <= take_now ? entry_pair : next_cc;
            jump_if_masked <= (take_now ? entry_pair : next_cc) == `NPIC_LVL3_PAT;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_take     <= 1'b0;
            irq_vec      <= `NPIC_VEC_NONE;
            lvl_before_q <= 2'h3;
        end else begin
            irq_take <= take_now;
            if (take_now) begin
                irq_vec      <= sel_vec;
                lvl_before_q <= cur_lvl;
            end
        end
    end

    // ---------------- run, wait and halt ----------------
    always_comb begin
        next_state = state;
        case (state)
            st_run: begin
                if (boundary_run && !take_now && instr_code == i_halt) begin
                    next_state = st_halt;
                end else if (boundary_run && !take_now && instr_code == i_wait) begin
                    next_state = st_wait;
                end
            end
            st_wait, st_halt: begin
                if (take_now) begin
                    next_state = st_run;
                end
            end
            default: next_state = st_run;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state   <= st_run;
            cpu_run <= 1'b1;
        end else begin
            state   <= next_state;
            cpu_run <= (next_state == st_run);
        end
    end

    // ---------------- checks ----------------
    default clocking npic_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence trap_boundary_s;
        instr_boundary && state == st_run && instr_code == i_trap;
    endsequence
    sequence trap_entry_s;
        irq_take && irq_vec == `NPIC_VEC_TRAP && cc == `NPIC_LVL3_PAT;
    endsequence
    sequence top_ready_s;
        pend[0] && top_en && state == st_run && instr_boundary && instr_code != i_trap;
    endsequence

    trap_served_a: assert property (trap_boundary_s |=> trap_entry_s)
        else $error("trap instruction not served at level 3");
    top_unmasked_a: assert property (top_ready_s |=> irq_take && irq_vec == `NPIC_VEC_TOP)
        else $error("top-level request not taken at boundary");
    top_entry_a: assert property (irq_take && irq_vec == `NPIC_VEC_TOP |-> cc == `NPIC_CC_TOP)
        else $error("top-level entry did not load level 3");
    entry_level_a: assert property (irq_take && irq_vec >= 4'h1 && irq_vec <= 4'hD
                                    |-> npic_lvl(cc) > lvl_before_q)
        else $error("maskable entry not above previous level");
    level0_keep_a: assert property (wr_pend && addr_q == `NPIC_OFF_PRIO0 &&
                                    hwdata[1:0] == `NPIC_LVL0_PAT |=> $stable(ispr[0][1:0]))
        else $error("level-0 pattern was stored");
    prio3_upper_a: assert property (ispr[3][7:4] == 4'hF)
        else $error("read-only nibble changed");
    main_level_a: assert property (boundary_run && instr_code == i_enable && !take_now
                                   |=> cc == `NPIC_LVL0_PAT && !jump_if_masked)
        else $error("enable instruction did not load main level");
    halt_first_a: assert property (state == st_halt ##1 irq_take |-> HALT_CAP[irq_vec])
        else $error("halt left through a non halt-capable source");
    edge_lock_a: assert property (top_en |=> $stable(top_sel))
        else $error("edge select changed while enabled");
    read_wait_a: assert property (accept && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
endmodule

// >>> tb/npic_core_model.sv
// core model: one instruction boundary per cycle and a stack of level pairs
`timescale 1ns/1ps
module npic_core_model
    import npic_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // bench control
    input  wire npic_instr_t cmd,
    input  wire logic [1:0]  pop_val,
    // controller side
    input  wire logic        irq_take,
    input  wire logic [1:0]  pair,
    input  wire logic        cpu_run,
    output npic_instr_t      instr_code,
    output logic             instr_boundary,
    output logic [1:0]       stack_prio
);
    logic [1:0] last_pair;
    logic [1:0] stk[$];
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            instr_boundary <= 1'b0;
            instr_code     <= i_none;
            stack_prio     <= 2'h3;
            last_pair      <= 2'h3;
            stk.delete();
        end else begin
            // a stopped core ends no instructions
            instr_boundary <= cpu_run;
            instr_code     <= cmd;
            // the stacked level is the one left by the instruction just ended
            if (instr_boundary && instr_code inside {i_enable, i_halt, i_wait})
                last_pair <= 2'h2;
            else if (instr_boundary && instr_code == i_disable)
                last_pair <= 2'h3;
            else if (instr_boundary && instr_code inside {i_pop, i_return})
                last_pair <= stack_prio;
            else
                last_pair <= pair;
            if (irq_take)
                stk.push_back(last_pair);
            stack_prio <= (cmd == i_pop) ? pop_val : ((stk.size() > 0) ? stk[$] : 2'h3);
            if (cmd == i_return && stk.size() > 0)
                void'(stk.pop_back());
        end
    end
endmodule

// >>> tb/nested_priority_interrupt_ctrl_bench.sv
// self-checking bench of the nested priority interrupt controller
`timescale 1ns/1ps
module nested_priority_interrupt_ctrl_bench;
    import npic_pkg::*;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, top_pin = 0, s;
    logic [1:0]  htrans = 2'h0, pop_val = 2'h0, pair, sp;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [13:0] flag = 14'h0, clr = 14'h0, en = 14'h3FFF;
    logic [15:0] ext = 16'h0;
    logic        hreadyout, hresp, irq_take, pbh, pbl, jm, run, ib;
    logic [3:0]  vec;
    npic_instr_t cmd = i_none, code;
    int          n_mismatch = 0, total_checks = 0;
    assign pair = {pbh, pbl};
    always #12.5 hclk = ~hclk;

    npic_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hready(hreadyout), .hwdata, .hreadyout, .hresp, .hrdata, .instr_boundary(ib),
        .instr_code(code), .stack_prio(sp), .irq_take, .irq_vec(vec), .prio_bit_high(pbh),
        .prio_bit_low(pbl), .jump_if_masked(jm), .cpu_run(run), .top_irq_pin(top_pin),
        .ext_irq_pins(ext), .periph_flag(flag), .periph_en(en), .periph_clear(clr));
    npic_core_model core (.hclk, .hresetn, .cmd, .pop_val, .irq_take, .pair,
        .cpu_run(run), .instr_code(code), .instr_boundary(ib), .stack_prio(sp));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {24'h0, a};
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
        chk(hresp, 1'b0);
    endtask
    task automatic go(input npic_instr_t c);
        @(posedge hclk);
        cmd <= c;
        @(posedge hclk);
        cmd <= i_none;
    endtask
    // flags are levels; the clear strobe lasts one cycle
    task automatic pf(input logic [13:0] f, input logic [13:0] c);
        @(posedge hclk);
        flag <= f;
        clr  <= c;
        @(posedge hclk);
        clr  <= 14'h0;
    endtask
    // looks just past each edge, since irq_take stands one cycle only
    task automatic wait_take(input int n);
        s = 1'b0;
        repeat (n) begin
            @(posedge hclk);
            #1;
            if (irq_take === 1'b1) begin
                s = 1'b1;
                break;
            end
        end
    endtask

    task automatic t_regs;
        for (int i = 1; i <= 4; i++) begin
            ahb(1'b0, 8'(4 * i), 32'h0);
            chk(r, 32'hFF);
        end
        ahb(1'b1, 8'h04, 32'h66);
        ahb(1'b0, 8'h04, 32'h0);
        chk(r, 32'h77);
        ahb(1'b1, 8'h10, 32'h0);
        ahb(1'b0, 8'h10, 32'h0);
        chk(r, 32'hF0);
        ahb(1'b0, 8'h40, 32'h0);
        chk(r, 32'h0);
        ahb(1'b0, 8'h00, 32'h0);
        chk(r, 32'hE8);
        chk({jm, pair}, 3'h7);
        $display("test regs done");
    endtask
    task automatic t_arb;
        ahb(1'b1, 8'h0C, 32'hF1);
        pf(14'h0300, 14'h0);
        wait_take(12);
        chk(s, 1'b0);
        go(i_enable);
        wait_take(40);
        chk({s, vec, pair}, {1'b1, 4'h9, 2'h0});
        wait_take(12);
        chk(s, 1'b0);
        pf(14'h0100, 14'h0200);
        go(i_return);
        wait_take(40);
        chk({s, vec, pair}, {1'b1, 4'h8, 2'h1});
        pf(14'h0, 14'h0100);
        go(i_return);
        ahb(1'b1, 8'h0C, 32'hF5);
        pf(14'h0300, 14'h0);
        wait_take(40);
        chk({s, vec, pair}, {1'b1, 4'h8, 2'h1});
        pf(14'h0, 14'h0300);
        go(i_disable);
        wait_take(12);
        chk({s, jm, pair}, {1'b0, 3'h7});
        pf(14'h0400, 14'h0);
        pf(14'h0, 14'h0400);
        go(i_enable);
        wait_take(12);
        chk(s, 1'b0);
        go(i_disable);
        $display("test arbitration done");
    endtask
    task automatic t_top;
        ahb(1'b1, 8'h14, 32'h3);
        ahb(1'b1, 8'h14, 32'h1);
        ahb(1'b0, 8'h14, 32'h0);
        chk(r, 32'h3);
        @(posedge hclk);
        top_pin <= 1'b1;
        wait_take(40);
        chk({s, vec, pair}, {1'b1, 4'h0, 2'h3});
        go(i_trap);
        wait_take(40);
        chk({s, vec, pair}, {1'b1, 4'hE, 2'h3});
        $display("test top-level and trap done");
    endtask
    task automatic t_sleep;
        ahb(1'b1, 8'h08, 32'h7F);
        ahb(1'b1, 8'h0C, 32'hF1);
        @(posedge hclk);
        pop_val <= 2'h1;
        go(i_pop);
        wait_take(12);
        chk({s, pair}, {1'b0, 2'h1});
        go(i_halt);
        wait_take(12);
        chk({s, run, pair}, {2'b00, 2'h2});
        pf(14'h0200, 14'h0);
        wait_take(12);
        chk({s, run}, 2'b00);
        pf(14'h0280, 14'h0);
        wait_take(40);
        chk({s, vec, pair, run}, {1'b1, 4'h7, 2'h1, 1'b1});
        wait_take(40);
        chk({s, vec, pair}, {1'b1, 4'h9, 2'h0});
        $display("test halt wake-up done");
    endtask

    // pins 4 and 5 of group 1 feed vector 3; vector 9 is gated by its enable
    task automatic t_ext;
        pf(14'h0, 14'h0280);
        ahb(1'b1, 8'h18, 32'h30);
        go(i_enable);
        @(posedge hclk);
        ext <= 16'h0020;
        wait_take(40);
        chk({s, vec, pair}, {1'b1, 4'h3, 2'h1});
        go(i_return);
        wait_take(12);
        chk(s, 1'b0);
        @(posedge hclk);
        ext <= 16'h0000;
        @(posedge hclk);
        ext <= 16'h0011;
        wait_take(40);
        chk({s, vec, pair}, {1'b1, 4'h3, 2'h1});
        @(posedge hclk);
        en <= 14'h3DFF;
        go(i_wait);
        pf(14'h0200, 14'h0);
        wait_take(12);
        chk({s, run}, 2'b00);
        @(posedge hclk);
        en <= 14'h3FFF;
        wait_take(40);
        chk({s, vec, run}, {1'b1, 4'h9, 1'b1});
        pf(14'h0, 14'h0200);
        $display("test external and wait done");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_arb;
        t_top;
        t_sleep;
        t_ext;
        tally_and_finish;
    end
    // the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge hclk);
        n_mismatch++;
        tally_and_finish;
    end
endmodule
